// >>> xeu_consts.vh
// constants for the cpu exception entry and return unit
`ifndef XEU_CONSTS_VH
`define XEU_CONSTS_VH

// ***************************************************************
// register byte offsets on the apb bus
// ***************************************************************
`define XEU_ADDR_W 8
`define XEU_OFS_STAT 8'h00
`define XEU_OFS_EPC 8'h04
`define XEU_OFS_EPSW 8'h08
`define XEU_OFS_CAUSE 8'h0c
`define XEU_OFS_DPC 8'h10
`define XEU_OFS_DPSW 8'h14

// ***************************************************************
// status word layout and reset value
// ***************************************************************
`define XEU_STAT_NMI 7
`define XEU_STAT_FAULT 6
`define XEU_STAT_IDIS 5
`define XEU_STAT_RST 32'h00000020
`define XEU_STAT_MASK 32'h000000ff
`define XEU_SAVE_RST 32'h00000000
`define XEU_CAUSE_RST 32'h00000000

// ***************************************************************
// handler addresses and cause codes
// ***************************************************************
`define XEU_VEC_TRAP_LO 32'h00000040
`define XEU_VEC_TRAP_HI 32'h00000050
`define XEU_VEC_DEBUG 32'h00000060
`define XEU_VEC_SPLIT_BIT 4
`define XEU_CAUSE_BASE 16'h0040

// ***************************************************************
// illegal opcode pattern
// ***************************************************************
`define XEU_ILG_OPC 6'h3f
`define XEU_ILG_SUB_MIN 4'h7
`define XEU_ILG_BIT16 1'b0

`endif

// >>> xeu_save_reg.v
// loadable save register, hardware load wins over software write
`timescale 1ns/1ps

module xeu_save_reg #(
  parameter W = 32,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire clk_sys,
  input wire rstn,
  input wire hw_ld,
  input wire [W-1:0] hw_d,
  input wire sw_ld,
  input wire [W-1:0] sw_d,
  output reg [W-1:0] q_r
);

  reg [W-1:0] q_nxt;

  always @* begin
    q_nxt = q_r;
    if (hw_ld) begin
      q_nxt = hw_d;
    end else if (sw_ld) begin
      q_nxt = sw_d;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule // xeu_save_reg

// >>> xeu_exc_unit.v
// cpu exception entry and return unit with apb register access
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "xeu_consts.vh"

module xeu_exc_unit #(
  parameter VEC_W = 5
) (
  input wire clk_sys,
  input wire rstn,
  input wire ex_valid,
  input wire [31:0] ex_op,
  input wire [31:0] ex_ret_pc,
  input wire ex_is_trap,
  input wire [VEC_W-1:0] ex_vector,
  input wire ex_is_eret,
  input wire ex_is_dbrk,
  input wire ex_is_dret,
  input wire mint_req,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`XEU_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  output reg redirect_r,
  output reg [31:0] redirect_pc_r,
  output reg [31:0] stat_word_r,
  output reg illegal_trap_r,
  output reg dbg_win_r,
  output reg mint_ack_r
);

  // ***************************************************************
  // instruction classification
  // ***************************************************************
  wire illegal_hit;
  wire take_ilg;
  wire take_dbt;
  wire take_trap;
  wire take_dret;
  wire take_eret;
  wire dbg_entry;
  wire any_entry;
  wire any_return;

  // illegal pattern checked on the raw opcode
  assign illegal_hit = (ex_op[10:5] == `XEU_ILG_OPC) &&
                       (ex_op[26:23] >= `XEU_ILG_SUB_MIN) &&
                       (ex_op[16] == `XEU_ILG_BIT16);

  // priority: illegal, debug break, trap, debug return, exception return
  assign take_ilg = ex_valid && illegal_hit;
  assign take_dbt = ex_valid && !illegal_hit && ex_is_dbrk;
  assign take_trap = ex_valid && !illegal_hit && !ex_is_dbrk &&
                     ex_is_trap;
  assign take_dret = ex_valid && !illegal_hit && !ex_is_dbrk && !ex_is_trap &&
                     ex_is_dret;
  assign take_eret = ex_valid && !illegal_hit && !ex_is_dbrk && !ex_is_trap &&
                     !ex_is_dret && ex_is_eret && stat_word_r[`XEU_STAT_FAULT];

  assign dbg_entry = take_ilg || take_dbt;
  assign any_entry = dbg_entry || take_trap;
  assign any_return = take_dret || take_eret;

  // ***************************************************************
  // apb decode
  // ***************************************************************
  wire apb_acc;
  wire hit_stat;
  wire hit_epc;
  wire hit_epsw;
  wire hit_cause;
  wire hit_dpc;
  wire hit_dpsw;
  wire hit_any;
  wire acc_err;
  wire wr_fire;
  wire wr_stat;
  wire wr_epc;
  wire wr_epsw;
  wire wr_cause;
  wire wr_dpc;
  wire wr_dpsw;

  assign apb_acc = psel && penable;
  assign hit_stat = (paddr == `XEU_OFS_STAT);
  assign hit_epc = (paddr == `XEU_OFS_EPC);
  assign hit_epsw = (paddr == `XEU_OFS_EPSW);
  assign hit_cause = (paddr == `XEU_OFS_CAUSE);
  assign hit_dpc = (paddr == `XEU_OFS_DPC);
  assign hit_dpsw = (paddr == `XEU_OFS_DPSW);
  assign hit_any = hit_stat || hit_epc || hit_epsw || hit_cause ||
                   hit_dpc || hit_dpsw;

  // debug pair closed outside the debug window
  assign acc_err = !hit_any || ((hit_dpc || hit_dpsw) && !dbg_win_r);

  // writes take effect on the completing edge only
  assign wr_fire = apb_acc && pready_r && pwrite && !pslverr_r;
  assign wr_stat = wr_fire && hit_stat;
  assign wr_epc = wr_fire && hit_epc;
  assign wr_epsw = wr_fire && hit_epsw;
  assign wr_cause = wr_fire && hit_cause;
  assign wr_dpc = wr_fire && hit_dpc && dbg_win_r;
  assign wr_dpsw = wr_fire && hit_dpsw && dbg_win_r;

  // ***************************************************************
  // save registers
  // ***************************************************************
  wire [31:0] epc_q;
  wire [31:0] epsw_q;
  wire [31:0] dpc_q;
  wire [31:0] dpsw_q;

  xeu_save_reg #(
    .W(32),
    .RST(`XEU_SAVE_RST)
  ) u_epc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .hw_ld(take_trap),
    .hw_d(ex_ret_pc),
    .sw_ld(wr_epc),
    .sw_d(pwdata),
    .q_r(epc_q)
  );

  xeu_save_reg #(
    .W(32),
    .RST(`XEU_SAVE_RST)
  ) u_epsw (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .hw_ld(take_trap),
    .hw_d(stat_word_r),
    .sw_ld(wr_epsw),
    .sw_d(pwdata & `XEU_STAT_MASK),
    .q_r(epsw_q)
  );

  xeu_save_reg #(
    .W(32),
    .RST(`XEU_SAVE_RST)
  ) u_dpc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .hw_ld(dbg_entry),
    .hw_d(ex_ret_pc),
    .sw_ld(wr_dpc),
    .sw_d(pwdata),
    .q_r(dpc_q)
  );

  xeu_save_reg #(
    .W(32),
    .RST(`XEU_SAVE_RST)
  ) u_dpsw (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .hw_ld(dbg_entry),
    .hw_d(stat_word_r),
    .sw_ld(wr_dpsw),
    .sw_d(pwdata & `XEU_STAT_MASK),
    .q_r(dpsw_q)
  );

  // ***************************************************************
  // status word and cause code
  // ***************************************************************
  reg [31:0] stat_word_nxt;
  reg [31:0] cause_r;
  reg [31:0] cause_nxt;
  wire [15:0] trap_code;

  assign trap_code = `XEU_CAUSE_BASE + {{(16-VEC_W){1'b0}}, ex_vector};

  always @* begin
    stat_word_nxt = stat_word_r;
    if (wr_stat) begin
      stat_word_nxt = pwdata & `XEU_STAT_MASK;
    end
    // hardware events win over a software write in the same cycle
    if (take_trap) begin
      stat_word_nxt = stat_word_r;
      stat_word_nxt[`XEU_STAT_FAULT] = 1'b1;
      stat_word_nxt[`XEU_STAT_IDIS] = 1'b1;
    end else if (dbg_entry) begin
      stat_word_nxt = stat_word_r;
      stat_word_nxt[`XEU_STAT_NMI] = 1'b1;
      stat_word_nxt[`XEU_STAT_FAULT] = 1'b1;
      stat_word_nxt[`XEU_STAT_IDIS] = 1'b1;
    end else if (take_dret) begin
      stat_word_nxt = dpsw_q & `XEU_STAT_MASK;
    end else if (take_eret) begin
      stat_word_nxt = epsw_q & `XEU_STAT_MASK;
    end
  end

  always @* begin
    cause_nxt = cause_r;
    if (wr_cause) begin
      cause_nxt = pwdata;
    end
    if (take_trap) begin
      cause_nxt[15:0] = trap_code;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stat_word_r <= `XEU_STAT_RST;
      cause_r <= `XEU_CAUSE_RST;
    end else begin
      stat_word_r <= stat_word_nxt;
      cause_r <= cause_nxt;
    end
  end

  // ***************************************************************
  // control transfer
  // ***************************************************************
  reg [31:0] target_nxt;

  always @* begin
    target_nxt = redirect_pc_r;
    if (take_trap) begin
      if (ex_vector[`XEU_VEC_SPLIT_BIT]) begin
        target_nxt = `XEU_VEC_TRAP_HI;
      end else begin
        target_nxt = `XEU_VEC_TRAP_LO;
      end
    end else if (dbg_entry) begin
      target_nxt = `XEU_VEC_DEBUG;
    end else if (take_dret) begin
      target_nxt = dpc_q;
    end else if (take_eret) begin
      target_nxt = epc_q;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      redirect_r <= 1'b0;
      redirect_pc_r <= 32'h00000000;
      illegal_trap_r <= 1'b0;
    end else begin
      redirect_r <= any_entry || any_return;
      redirect_pc_r <= target_nxt;
      illegal_trap_r <= take_ilg;
    end
  end

  // ***************************************************************
  // debug save window
  // ***************************************************************
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dbg_win_r <= 1'b0;
    end else if (dbg_entry) begin
      dbg_win_r <= 1'b1;
    end else if (take_dret) begin
      dbg_win_r <= 1'b0;
    end
  end

  // ***************************************************************
  // maskable interrupt gate
  // ***************************************************************
  // request stays pending while interrupts are disabled or an exception is entered
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mint_ack_r <= 1'b0;
    end else begin
      mint_ack_r <= mint_req && !stat_word_r[`XEU_STAT_IDIS] && !any_entry;
    end
  end

  // ***************************************************************
  // apb read path and ready
  // ***************************************************************
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_stat) begin
      rd_mux = stat_word_r;
    end else if (hit_epc) begin
      rd_mux = epc_q;
    end else if (hit_epsw) begin
      rd_mux = epsw_q;
    end else if (hit_cause) begin
      rd_mux = cause_r;
    end else if (hit_dpc && dbg_win_r) begin
      rd_mux = dpc_q;
    end else if (hit_dpsw && dbg_win_r) begin
      rd_mux = dpsw_q;
    end
  end

  // one wait state: ready rises in the second access cycle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (apb_acc && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= acc_err;
      prdata_r <= (pwrite || acc_err) ? 32'h00000000 : rd_mux;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
  end

endmodule // xeu_exc_unit

// >>> xeu_exc_props.sv
// assertion checker for the exception entry and return unit
`timescale 1ns/1ps
module xeu_exc_props #(
  parameter VEC_W = 5
) (
  input wire clk_sys,
  input wire rstn,
  input wire ex_valid,
  input wire [31:0] ex_op,
  input wire ex_is_trap,
  input wire [VEC_W-1:0] ex_vector,
  input wire ex_is_eret,
  input wire ex_is_dbrk,
  input wire ex_is_dret,
  input wire mint_req,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready_r,
  input wire pslverr_r,
  input wire redirect_r,
  input wire [31:0] redirect_pc_r,
  input wire [31:0] stat_word_r,
  input wire illegal_trap_r,
  input wire dbg_win_r,
  input wire mint_ack_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire ill = ex_op[10:5] == 6'h3f && ex_op[26:23] >= 4'h7 && !ex_op[16];
  wire ins = ex_valid && !ill;
  wire trap = ins && ex_is_trap && !ex_is_dbrk;
  wire dpair = paddr == 8'h10 || paddr == 8'h14;
  trap_target_a: assert property (
    trap |=> redirect_r && redirect_pc_r == ($past(ex_vector[4]) ? 32'h50 : 32'h40))
    else $error("trap target wrong");
  trap_flags_a: assert property (
    trap |=> stat_word_r[6] && stat_word_r[5] && !illegal_trap_r)
    else $error("trap flags wrong");
  ill_entry_a: assert property (
    ex_valid && ill |=> illegal_trap_r && redirect_r && redirect_pc_r == 32'h60
    && stat_word_r[7:5] == 3'h7 && dbg_win_r) else $error("illegal entry wrong");
  dbg_entry_a: assert property (
    ins && ex_is_dbrk |=> redirect_r && redirect_pc_r == 32'h60 && stat_word_r[7:5] == 3'h7
    && dbg_win_r && !illegal_trap_r) else $error("debug entry wrong");
  eret_idle_a: assert property (
    ins && ex_is_eret && !ex_is_trap && !ex_is_dbrk && !ex_is_dret && !stat_word_r[6]
    |=> !redirect_r) else $error("return taken outside exception");
  dret_close_a: assert property (
    ins && ex_is_dret && !ex_is_trap && !ex_is_dbrk |=> redirect_r && !dbg_win_r)
    else $error("debug return wrong");
  ack_masked_a: assert property (
    stat_word_r[5] |=> !mint_ack_r) else $error("ack while disabled");
  ack_open_a: assert property (
    mint_req && !stat_word_r[5] && !ex_valid |=> mint_ack_r) else $error("ack missing");
  apb_wait_a: assert property (
    psel && !penable |=> !pready_r ##1 pready_r) else $error("apb wait wrong");
  pair_refuse_a: assert property (
    psel && !penable && !ex_valid && !dbg_win_r && dpair |=> ##1 pslverr_r)
    else $error("debug pair not refused");
endmodule // xeu_exc_props
bind xeu_exc_unit xeu_exc_props #(.VEC_W(VEC_W)) i_props (.clk_sys(clk_sys), .rstn(rstn),
  .ex_valid(ex_valid), .ex_op(ex_op), .ex_is_trap(ex_is_trap), .ex_vector(ex_vector),
  .ex_is_eret(ex_is_eret), .ex_is_dbrk(ex_is_dbrk), .ex_is_dret(ex_is_dret),
  .mint_req(mint_req), .psel(psel), .penable(penable), .paddr(paddr),
  .pready_r(pready_r), .pslverr_r(pslverr_r), .redirect_r(redirect_r),
  .redirect_pc_r(redirect_pc_r), .stat_word_r(stat_word_r), .illegal_trap_r(illegal_trap_r),
  .dbg_win_r(dbg_win_r), .mint_ack_r(mint_ack_r));

// >>> xeu_pipe_model.sv
// pipeline model presenting one executed instruction per call
`timescale 1ns/1ps
module xeu_pipe_model (
  input wire clk_sys,
  output reg ex_valid,
  output reg [31:0] ex_op,
  output reg [31:0] ex_ret_pc,
  output reg ex_is_trap,
  output reg [4:0] ex_vector,
  output reg ex_is_eret,
  output reg ex_is_dbrk,
  output reg ex_is_dret
);
  initial begin
    {ex_valid, ex_is_trap, ex_is_eret, ex_is_dbrk, ex_is_dret} = 5'h00;
    ex_op = 32'hffffffff;
    ex_ret_pc = 32'hffffffff;
    ex_vector = 5'h1f;
  end
  // kind 1 trap, 2 return, 3 debug break, 4 debug return
  task issue(input [2:0] k, input [31:0] op, input [31:0] pc, input [4:0] v);
    begin
      // drive right after an edge, hold through the sampling edge
      @(posedge clk_sys);
      ex_valid <= 1'b1;
      ex_op <= op;
      ex_ret_pc <= pc;
      ex_vector <= v;
      ex_is_trap <= k == 3'h1;
      ex_is_eret <= k == 3'h2;
      ex_is_dbrk <= k == 3'h3;
      ex_is_dret <= k == 3'h4;
      @(posedge clk_sys);
      // idle buses show no stale value
      {ex_valid, ex_is_trap, ex_is_eret, ex_is_dbrk, ex_is_dret} <= 5'h00;
      ex_op <= ~op;
      ex_ret_pc <= ~pc;
      ex_vector <= ~v;
    end
  endtask
endmodule // xeu_pipe_model

// >>> tb.sv
// self-checking bench for the exception entry and return unit
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [2:0] k; logic [31:0] op; logic [31:0] pc; logic [4:0] v;
    logic rd; logic [31:0] tgt; logic [31:0] stat; logic ilg; logic win;
  } xeu_row_t;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg mint_req = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  wire ex_valid, ex_is_trap, ex_is_eret, ex_is_dbrk, ex_is_dret;
  wire [31:0] ex_op, ex_ret_pc, prdata_r, redirect_pc_r, stat_word_r;
  wire [4:0] ex_vector;
  wire pready_r, pslverr_r, redirect_r, illegal_trap_r, dbg_win_r, mint_ack_r;
  integer bad_count = 0;
  integer compares = 0;
  integer i;
  reg [31:0] rd;
  reg err;
  xeu_row_t rows [0:11];
  xeu_pipe_model i_pipe (.clk_sys(clk_sys), .ex_valid(ex_valid), .ex_op(ex_op),
    .ex_ret_pc(ex_ret_pc), .ex_is_trap(ex_is_trap), .ex_vector(ex_vector),
    .ex_is_eret(ex_is_eret), .ex_is_dbrk(ex_is_dbrk), .ex_is_dret(ex_is_dret));
  xeu_exc_unit i_dut (.clk_sys(clk_sys), .rstn(rstn), .ex_valid(ex_valid), .ex_op(ex_op),
    .ex_ret_pc(ex_ret_pc), .ex_is_trap(ex_is_trap), .ex_vector(ex_vector),
    .ex_is_eret(ex_is_eret), .ex_is_dbrk(ex_is_dbrk), .ex_is_dret(ex_is_dret),
    .mint_req(mint_req), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .redirect_r(redirect_r), .redirect_pc_r(redirect_pc_r), .stat_word_r(stat_word_r),
    .illegal_trap_r(illegal_trap_r), .dbg_win_r(dbg_win_r), .mint_ack_r(mint_ack_r));
  always #50 clk_sys = ~clk_sys;
  task chk(input string n, input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("wrong value %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // look at settled values, then complete on the next edge
      do begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end while (pready_r !== 1'b1 && n < 20);
      if (n == 20) bad_count = bad_count + 1;
      rd = prdata_r;
      err = pslverr_r;
      @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task final_report;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #300000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    // kind, opcode, return pc, vector, redirect, target, status, illegal, window
    rows[0] = '{3'h1, 32'h0, 32'h100, 5'h0f, 1'b1, 32'h40, 32'h60, 1'b0, 1'b0};
    rows[1] = '{3'h2, 32'h0, 32'h0, 5'h00, 1'b1, 32'h100, 32'h20, 1'b0, 1'b0};
    rows[2] = '{3'h2, 32'h0, 32'h0, 5'h00, 1'b0, 32'h100, 32'h20, 1'b0, 1'b0};
    rows[3] = '{3'h1, 32'h0, 32'h200, 5'h10, 1'b1, 32'h50, 32'h60, 1'b0, 1'b0};
    rows[4] = '{3'h1, 32'h038007e0, 32'h300, 5'h00, 1'b1, 32'h60, 32'he0, 1'b1, 1'b1};
    rows[5] = '{3'h4, 32'h0, 32'h0, 5'h00, 1'b1, 32'h300, 32'h60, 1'b0, 1'b0};
    rows[6] = '{3'h2, 32'h0, 32'h0, 5'h00, 1'b1, 32'h200, 32'h20, 1'b0, 1'b0};
    rows[7] = '{3'h0, 32'h030007e0, 32'h0, 5'h00, 1'b0, 32'h200, 32'h20, 1'b0, 1'b0};
    rows[8] = '{3'h0, 32'h038107e0, 32'h0, 5'h00, 1'b0, 32'h200, 32'h20, 1'b0, 1'b0};
    rows[9] = '{3'h0, 32'h078007e0, 32'h500, 5'h00, 1'b1, 32'h60, 32'he0, 1'b1, 1'b1};
    rows[10] = '{3'h3, 32'h0, 32'h600, 5'h00, 1'b1, 32'h60, 32'he0, 1'b0, 1'b1};
    rows[11] = '{3'h4, 32'h0, 32'h0, 5'h00, 1'b1, 32'h600, 32'he0, 1'b0, 1'b0};
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("reset status", stat_word_r, 32'h20);
    chk("reset window", {31'h0, dbg_win_r}, 32'h0);
    for (i = 0; i < 12; i = i + 1) begin
      i_pipe.issue(rows[i].k, rows[i].op, rows[i].pc, rows[i].v);
      #1;
      chk("redirect", {31'h0, redirect_r}, {31'h0, rows[i].rd});
      chk("target", redirect_pc_r, rows[i].tgt);
      chk("status", stat_word_r, rows[i].stat);
      chk("illegal", {31'h0, illegal_trap_r}, {31'h0, rows[i].ilg});
      chk("window", {31'h0, dbg_win_r}, {31'h0, rows[i].win});
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("closed pair error", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("saved counter", rd, 32'h200);
    chk("read error", {31'h0, err}, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("saved status", rd, 32'h20);
    apb(1'b1, 8'h0c, 32'habcd0000);
    apb(1'b1, 8'h00, 32'h0);
    mint_req <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("ack open", {31'h0, mint_ack_r}, 32'h1);
    i_pipe.issue(3'h1, 32'h0, 32'h700, 5'h05);
    @(posedge clk_sys);
    #1;
    chk("ack held off", {31'h0, mint_ack_r}, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("cause", rd, 32'habcd0045);
    i_pipe.issue(3'h3, 32'h0, 32'h800, 5'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk("debug counter", rd, 32'h800);
    apb(1'b0, 8'h14, 32'h0);
    chk("debug status", rd, 32'h60);
    apb(1'b1, 8'h10, 32'h900);
    i_pipe.issue(3'h4, 32'h0, 32'h0, 5'h00);
    #1;
    chk("debug return", redirect_pc_r, 32'h900);
    chk("restored status", stat_word_r, 32'h60);
    apb(1'b0, 8'h14, 32'h0);
    chk("window closed", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    // second reset in mid-run, then a trap at the top vector
    rstn <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("mid reset status", stat_word_r, 32'h20);
    chk("mid reset target", redirect_pc_r, 32'h0);
    @(posedge clk_sys);
    rstn <= 1'b1;
    i_pipe.issue(3'h1, 32'h0, 32'ha00, 5'h1f);
    #1;
    chk("top vector target", redirect_pc_r, 32'h50);
    chk("top vector status", stat_word_r, 32'h60);
    apb(1'b0, 8'h04, 32'h0);
    chk("top vector counter", rd, 32'ha00);
    apb(1'b0, 8'h0c, 32'h0);
    chk("top vector cause", rd, 32'h0000005f);
    final_report;
  end
endmodule // tb
